// *** abx_checker.sv ***
`timescale 1ns/1ps
module abx_checker
  import abx_pkg::*;
#(parameter int PC_W = 21) (
  input logic clk,
  input logic rstn,
  input logic [15:0] instr,
  input logic [PC_W-1:0] pc,
  input abx_phase_t phase,
  input logic idle_cycle,
  input logic [7:0] accumulator,
  input abx_flags_t status,
  input abx_mem_t mem
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // word taken at decode
  sequence s_take(op); phase == ABX_Q1 && !idle_cycle && instr[15:8] == op; endsequence
  a_phase_walk: assert property (
    phase == ABX_Q1 |=> phase == ABX_Q2 ##1 phase == ABX_Q3) else $error("phase");
  a_late_write: assert property (
    phase != ABX_Q1 |-> $stable(pc) && $stable(accumulator)) else $error("early");
  a_store_pulse: assert property (
    mem.we |-> phase == ABX_Q1 ##1 !mem.we) else $error("store");
  a_idle_len: assert property (
    $rose(idle_cycle) |-> idle_cycle[*4] ##1 !idle_cycle) else $error("idle");
  a_add_lit: assert property (
    s_take(8'h0f) |-> ##4 accumulator == 8'($past(accumulator, 4) + $past(instr[7:0], 4)))
    else $error("add");
  a_and_lit: assert property (
    s_take(8'h0b) |-> ##4 status.c == $past(status.c, 4)
    && accumulator == ($past(accumulator, 4) & $past(instr[7:0], 4))) else $error("and");
  a_br_taken: assert property (
    s_take(8'he2) ##0 status.c |-> ##4 idle_cycle && pc == $past(pc, 4) + PC_W'(2)
    + {{(PC_W-9){$past(instr[7], 4)}}, $past(instr[7:0], 4), 1'b0}) else $error("taken");
  a_br_skip: assert property (
    s_take(8'he2) ##0 !status.c |-> ##4 pc == $past(pc, 4) + PC_W'(2)) else $error("skip");
endmodule : abx_checker
bind abx_core abx_checker #(.PC_W(PC_W)) i_chk (.*);

// *** abx_core.sv ***
`timescale 1ns/1ps

// Behaviour
// - add-file pattern 0010 01da adds accumulator and byte, updates all five flags.
// - destination bit zero writes accumulator, one writes the data memory byte.
// - access bit zero uses fixed access bank, one uses bank select register.
// - add-with-carry 0010 00da sums accumulator, byte and carry; updates five flags.
// - AND literal 0000 1011 into accumulator; only N and Z change.
// - AND-file 0001 01da ANDs accumulator with byte to destination; only N, Z.
// - branch 1110 0010 with signed offset -128..127 branches only when carry set.
// - taken target is branch address plus 2 plus twice the offset.
// - taken branch takes two cycles, second idle; not taken takes one.
module abx_core
  import abx_pkg::*;
#(
  parameter int PC_W = 21
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] instr,
  input wire logic [3:0] bank_select_register,
  input wire logic [7:0] mem_rdata,
  output logic [PC_W-1:0] pc,
  output abx_phase_t phase,
  output logic idle_cycle,
  output logic [7:0] accumulator,
  output abx_flags_t status,
  output abx_mem_t mem
);

  // whole state of the core
  typedef struct packed {
    abx_phase_t phase;
    logic idle;
    logic [15:0] ir;
    abx_op_t op;
    logic [7:0] acc;
    abx_flags_t flags;
    logic [7:0] res;
    abx_flags_t res_flags;
    logic taken;
    logic [PC_W-1:0] pc;
    abx_mem_t mem;
  } abx_state_t;

  abx_state_t st_ff;
  abx_state_t nxt_st;

  // elaboration check: the counter must hold a full branch span
  if (PC_W < 10) begin : g_pc_w_check
    $error("abx_core: PC_W must be at least 10");
  end

  // elaboration check: the sign extension of the offset needs a bounded width
  if (PC_W > 32) begin : g_pc_w_max_check
    $error("abx_core: PC_W must be at most 32");
  end

  // fields of the word held since decode
  logic [7:0] ir_f;
  logic ir_access;
  logic ir_dest;
  assign ir_f = st_ff.ir[7:0];
  assign ir_access = st_ff.ir[`ABX_BIT_ACCESS];
  assign ir_dest = st_ff.ir[`ABX_BIT_DEST];

  // which forms read a data byte and which write it back
  logic file_op;
  logic writes_file;
  logic writes_result;
  assign file_op = (st_ff.op == ABX_OP_ADD_FILE) || (st_ff.op == ABX_OP_ADC_FILE) ||
                   (st_ff.op == ABX_OP_AND_FILE);
  assign writes_file = file_op && ir_dest;
  assign writes_result = (st_ff.op != ABX_OP_NONE) && (st_ff.op != ABX_OP_BR_CARRY);

  // banked address: access bank split at the split offset, else bank select input
  logic [3:0] addr_bank;
  assign addr_bank = ir_access ? bank_select_register :
                     (ir_f < `ABX_ACC_SPLIT) ? `ABX_ACC_LO_BANK : `ABX_ACC_HI_BANK;

  // second operand: data byte for file forms, literal otherwise
  logic [7:0] alu_opb;
  logic alu_cin;
  assign alu_opb = file_op ? mem_rdata : ir_f;
  // carry in only for the add-with-carry form, as it stood before the word
  assign alu_cin = (st_ff.op == ABX_OP_ADC_FILE) ? st_ff.flags.c : 1'b0;

  // full and low-nibble sums give carry and nibble carry
  logic [8:0] alu_sum;
  logic [4:0] alu_lo;
  assign alu_sum = {1'b0, st_ff.acc} + {1'b0, alu_opb} + {8'h00, alu_cin};
  assign alu_lo = {1'b0, st_ff.acc[3:0]} + {1'b0, alu_opb[3:0]} + {4'h0, alu_cin};

  // add flags: all five follow the sum
  abx_flags_t add_flags;
  assign add_flags = '{
    n: alu_sum[7],
    signed_wrap: (st_ff.acc[7] == alu_opb[7]) && (alu_sum[7] != st_ff.acc[7]),
    z: (alu_sum[7:0] == 8'h00),
    nibble_carry: alu_lo[4],
    c: alu_sum[8]
  };

  // logic result: only negative and zero change, the rest carry over
  logic [7:0] and_res;
  abx_flags_t and_flags;
  assign and_res = st_ff.acc & alu_opb;
  assign and_flags = '{
    n: and_res[7],
    signed_wrap: st_ff.flags.signed_wrap,
    z: (and_res == 8'h00),
    nibble_carry: st_ff.flags.nibble_carry,
    c: st_ff.flags.c
  };

  // branch target: counter after the increment plus twice the signed offset
  logic [PC_W-1:0] pc_seq;
  logic [PC_W-1:0] br_ofs;
  logic [PC_W-1:0] pc_br;
  assign pc_seq = st_ff.pc + PC_W'(2);
  assign br_ofs = PC_W'({{(PC_W - 8){ir_f[7]}}, ir_f});
  assign pc_br = pc_seq + (br_ofs << 1);

  // next state: one phase per clock
  always_comb begin
    nxt_st = st_ff;
    nxt_st.mem.we = 1'b0;
    case (st_ff.phase)
      ABX_Q1: begin
        // decode; the word after a taken branch is ignored
        nxt_st.phase = ABX_Q2;
        nxt_st.ir = instr;
        nxt_st.taken = 1'b0;
        if (st_ff.idle) begin
          nxt_st.op = ABX_OP_NONE;
        end else begin
          nxt_st.op = abx_decode(instr);
        end
      end
      ABX_Q2: begin
        // operand read: present the banked address
        nxt_st.phase = ABX_Q3;
        nxt_st.mem.addr = {addr_bank, ir_f};
      end
      ABX_Q3: begin
        // process data into the result and its flags
        nxt_st.phase = ABX_Q4;
        case (st_ff.op)
          ABX_OP_ADD_IMM, ABX_OP_ADD_FILE, ABX_OP_ADC_FILE: begin
            nxt_st.res = alu_sum[7:0];
            nxt_st.res_flags = add_flags;
          end
          ABX_OP_AND_IMM, ABX_OP_AND_FILE: begin
            nxt_st.res = and_res;
            nxt_st.res_flags = and_flags;
          end
          ABX_OP_BR_CARRY: begin
            // the decision uses the carry as it stands now
            nxt_st.taken = st_ff.flags.c;
            nxt_st.res_flags = st_ff.flags;
          end
          default: begin
            // unknown words leave result and flags alone
            nxt_st.res_flags = st_ff.flags;
          end
        endcase
      end
      ABX_Q4: begin
        // write destination and advance the counter
        nxt_st.phase = ABX_Q1;
        nxt_st.idle = st_ff.taken;
        if (!st_ff.idle) begin
          if (writes_result) begin
            nxt_st.flags = st_ff.res_flags;
            if (writes_file) begin
              nxt_st.mem.we = 1'b1;
              nxt_st.mem.wdata = st_ff.res;
            end else begin
              nxt_st.acc = st_ff.res;
            end
          end
          if (st_ff.taken) begin
            nxt_st.pc = pc_br;
          end else begin
            nxt_st.pc = pc_seq;
          end
        end
      end
      default: begin
        nxt_st.phase = ABX_Q1;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from state
  assign pc = st_ff.pc;
  assign phase = st_ff.phase;
  assign idle_cycle = st_ff.idle;
  assign accumulator = st_ff.acc;
  assign status = st_ff.flags;
  assign mem = st_ff.mem;

endmodule : abx_core

// *** abx_dmem.sv ***
`timescale 1ns/1ps
module abx_dmem
  import abx_pkg::*;
(
  input logic clk,
  input abx_mem_t mem,
  output logic [7:0] mem_rdata
);
  logic [7:0] m [4096];
  // address pattern at start, stores on the strobe
  initial for (int i = 0; i < 4096; i++) m[i] = 8'(i) ^ 8'h5a;
  always @(posedge clk) if (mem.we) m[mem.addr] <= mem.wdata;
  assign mem_rdata = m[mem.addr];
endmodule : abx_dmem

// *** abx_params.svh ***
`ifndef ABX_PARAMS_SVH
`define ABX_PARAMS_SVH

// clock and instruction cycle
`define ABX_CLK_NS 100
`define ABX_PHASES 4
`define ABX_CYCLE_NS (`ABX_CLK_NS * `ABX_PHASES)

// opcode fields of the 16-bit instruction word
`define ABX_OPC_ADD_IMM 8'h0f
`define ABX_OPC_AND_IMM 8'h0b
`define ABX_OPC_BR_CARRY 8'he2
`define ABX_OPF_ADD_FILE 6'h09
`define ABX_OPF_ADC_FILE 6'h08
`define ABX_OPF_AND_FILE 6'h05
`define ABX_BIT_DEST 9
`define ABX_BIT_ACCESS 8

// fixed access bank: low half from bank 0, high half from the top bank
`define ABX_ACC_SPLIT 8'h80
`define ABX_ACC_LO_BANK 4'h0
`define ABX_ACC_HI_BANK 4'hf

// reset values
`define ABX_ACC_RST 8'h00
`define ABX_BANK_RST 12'h000

`endif

// *** abx_pkg.sv ***
package abx_pkg;
  `include "abx_params.svh"

  // gray-coded phase of the instruction cycle
  typedef enum logic [1:0] {
    ABX_Q1 = 2'h0,
    ABX_Q2 = 2'h1,
    ABX_Q3 = 2'h3,
    ABX_Q4 = 2'h2
  } abx_phase_t;

  typedef enum logic [2:0] {
    ABX_OP_NONE = 3'h0,
    ABX_OP_ADD_IMM = 3'h1,
    ABX_OP_ADD_FILE = 3'h2,
    ABX_OP_ADC_FILE = 3'h3,
    ABX_OP_AND_IMM = 3'h4,
    ABX_OP_AND_FILE = 3'h5,
    ABX_OP_BR_CARRY = 3'h6
  } abx_op_t;

  typedef struct packed {
    logic n;
    logic signed_wrap;
    logic z;
    logic nibble_carry;
    logic c;
  } abx_flags_t;

  typedef struct packed {
    logic [11:0] addr;
    logic we;
    logic [7:0] wdata;
  } abx_mem_t;

  // decode of one instruction word
  function automatic abx_op_t abx_decode(input logic [15:0] w);
    abx_op_t op;
    op = ABX_OP_NONE;
    if (w[15:8] == `ABX_OPC_ADD_IMM) op = ABX_OP_ADD_IMM;
    else if (w[15:8] == `ABX_OPC_AND_IMM) op = ABX_OP_AND_IMM;
    else if (w[15:8] == `ABX_OPC_BR_CARRY) op = ABX_OP_BR_CARRY;
    else if (w[15:10] == `ABX_OPF_ADD_FILE) op = ABX_OP_ADD_FILE;
    else if (w[15:10] == `ABX_OPF_ADC_FILE) op = ABX_OP_ADC_FILE;
    else if (w[15:10] == `ABX_OPF_AND_FILE) op = ABX_OP_AND_FILE;
    return op;
  endfunction : abx_decode
endpackage : abx_pkg

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  import abx_pkg::*;
  logic clk = 0, rstn = 0, idle_cycle;
  logic [15:0] instr = 16'hffff;
  logic [3:0] bank_select_register = 4'h3;
  logic [7:0] mem_rdata, accumulator;
  logic [20:0] pc, p;
  abx_phase_t phase;
  abx_flags_t status;
  abx_mem_t mem;
  int n_mismatch = 0, comparisons = 0;
  abx_core i_dut (.*);
  abx_dmem i_mem (.*);
  // 100 ns clock
  initial forever #50 clk = ~clk;
  task chk(string s, logic [20:0] e, g);
    comparisons++;
    n_mismatch += int'(g !== e);
    if (g !== e) $display("[FAIL] %s expected %h seen %h", s, e, g);
  endtask : chk
  // word, then filler; returns where results show
  task exec(logic [15:0] w);
    repeat (3) @(posedge clk);
    instr <= w;
    repeat (4) @(posedge clk);
    instr <= 16'hffff;
    @(posedge clk);
    @(negedge clk);
  endtask : exec
  task t_lit;
    exec(16'h0f80);
    exec(16'h0fa3);
    chk("flags", 21'h09, status);
    exec(16'h0bc0);
    chk("flags", 21'h0d, status);
  endtask : t_lit
  task t_br;
    p = pc;
    exec(16'he2fe);
    chk("target", p, pc);
    exec(16'h0f00);
    exec(16'he27f);
    chk("next", p + 21'h6, pc);
  endtask : t_br
  task t_file;
    exec(16'h0ff0);
    exec(16'h2740);
    chk("addr", 21'h340, mem.addr);
    chk("sum", 21'h0a, mem.wdata);
    exec(16'h2090);
    chk("addr", 21'hf90, mem.addr);
    chk("acc", 21'hbb, accumulator);
    exec(16'h1620);
    chk("and", 21'h3a, mem.wdata);
  endtask : t_file
  task conclude;
    $display("mismatches %0d checks %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // reset, then scenarios
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    t_lit();
    t_br();
    t_file();
    conclude();
  end
endmodule : tb
